// File: core/agr_config_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Gain register at 03h, reset 00h: delay 7:5, amp enable 4:3, gain 2:0.
// - Delay code sets start wait: 14,25,64,256,1024,2048,4096 periods; 111 is one.
// - Amp enable 00 bypasses and powers down amplifier, 01 enables it.
// - Gain code selects amplifier gain of two to the code power.
// - Rate register at 04h, reset 14h: chop, clock, mode, filter, rate.
// - Chop set swaps inputs and averages two readings; clear means no swap.
// - Clock bit clear picks internal oscillator, set picks external clock.
// - Mode bit clear gives continuous, set gives single-shot conversions.
// - Filter bit clear picks sinc3, set picks low-latency filter.
// - Rate code 0 to 14 raises output rate; 1111 reserved.
// - Reference register at 05h, reset 10h, with monitor, buffers, select, config.
// - Internal reference config: 00 off, 01 on except power-down, 10 always on.
// - Source select: 00 first pair, 01 second pair, 10 internal reference.
module agr_config_regs (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Modulator timing and power state
    input wire logic MOD_TICK,
    input wire logic POWER_DOWN,
    // Amplifier controls
    output logic AMP_POWERED,
    output logic AMP_BYPASS,
    output logic [7:0] AMP_GAIN,
    // Modulator and filter controls
    output logic CHOP_EN,
    output logic CLK_EXT_SEL,
    output logic SINGLE_SHOT,
    output logic FILTER_LOW_LAT,
    output logic [3:0] OUTPUT_RATE_CODE,
    output logic RATE_VALID,
    // Reference controls
    output logic [1:0] VSOURCE_MONITOR_CFG,
    output logic POS_VSOURCE_BUFFER_BYPASS,
    output logic NEG_VSOURCE_BUFFER_BYPASS,
    output logic [2:0] VSOURCE_PAIR_ONEHOT,
    output logic INT_VSOURCE_ON,
    // Conversion start delay
    output logic START_WAIT_BUSY,
    output logic START_READY
);
    logic [7:0] gain_r;
    logic [7:0] rate_r;
    logic [7:0] vsrc_r;
    logic cfg_wr;
    logic [1:0] amp_en;
    logic [1:0] vsel;
    logic [1:0] vcfg;

    // Write path; all codes stored as written
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            gain_r <= agr_pkg::RST_AMP_GAIN;
        end else if (CE && WR && ADDR == agr_pkg::OFS_AMP_GAIN) begin
            gain_r <= WDATA;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rate_r <= agr_pkg::RST_SAMPLE_RATE;
        end else if (CE && WR && ADDR == agr_pkg::OFS_SAMPLE_RATE) begin
            rate_r <= WDATA;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            vsrc_r <= agr_pkg::RST_VSOURCE;
        end else if (CE && WR && ADDR == agr_pkg::OFS_VSOURCE) begin
            vsrc_r <= WDATA;
        end
    end

    // Read data valid the cycle after the strobe; unmapped reads as zero
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            if (RD) begin
                case (ADDR)
                    agr_pkg::OFS_AMP_GAIN: RDATA <= gain_r;
                    agr_pkg::OFS_SAMPLE_RATE: RDATA <= rate_r;
                    agr_pkg::OFS_VSOURCE: RDATA <= vsrc_r;
                    default: RDATA <= 8'h00;
                endcase
            end else begin
                RDATA <= 8'h00;
            end
        end
    end

    assign amp_en = gain_r[agr_pkg::AMP_EN_LSB +: 2];
    assign vsel = vsrc_r[agr_pkg::VSEL_LSB +: 2];
    assign vcfg = vsrc_r[agr_pkg::VCFG_LSB +: 2];

    // Amplifier decode; reserved enable codes keep it bypassed
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            AMP_POWERED <= 1'b0;
            AMP_BYPASS <= 1'b1;
            AMP_GAIN <= 8'h01;
        end else if (CE) begin
            AMP_POWERED <= (amp_en == agr_pkg::AMP_EN_ON);
            AMP_BYPASS <= (amp_en != agr_pkg::AMP_EN_ON);
            // Bypass relies on software writing gain 000
            AMP_GAIN <= 8'h01 << gain_r[agr_pkg::GAIN_LSB +: 3];
        end
    end

    // Modulator and filter controls
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            CHOP_EN <= 1'b0;
            CLK_EXT_SEL <= 1'b0;
            SINGLE_SHOT <= 1'b0;
            FILTER_LOW_LAT <= 1'b1;
            OUTPUT_RATE_CODE <= 4'h4;
            RATE_VALID <= 1'b1;
        end else if (CE) begin
            CHOP_EN <= rate_r[agr_pkg::CHOP_BIT];
            CLK_EXT_SEL <= rate_r[agr_pkg::CLKSRC_BIT];
            SINGLE_SHOT <= rate_r[agr_pkg::MODE_BIT];
            FILTER_LOW_LAT <= rate_r[agr_pkg::FILTER_BIT];
            OUTPUT_RATE_CODE <= rate_r[agr_pkg::RATE_LSB +: 4];
            RATE_VALID <= (rate_r[agr_pkg::RATE_LSB +: 4] != agr_pkg::RATE_RSVD);
        end
    end

    // Reference controls; reserved select code selects no source
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            VSOURCE_MONITOR_CFG <= 2'h0;
            POS_VSOURCE_BUFFER_BYPASS <= 1'b0;
            NEG_VSOURCE_BUFFER_BYPASS <= 1'b1;
            VSOURCE_PAIR_ONEHOT <= 3'h1;
            INT_VSOURCE_ON <= 1'b0;
        end else if (CE) begin
            VSOURCE_MONITOR_CFG <= vsrc_r[agr_pkg::MON_LSB +: 2];
            POS_VSOURCE_BUFFER_BYPASS <= vsrc_r[agr_pkg::POS_BUF_BIT];
            NEG_VSOURCE_BUFFER_BYPASS <= vsrc_r[agr_pkg::NEG_BUF_BIT];
            VSOURCE_PAIR_ONEHOT <= {vsel == agr_pkg::VSEL_INT,
                                    vsel == agr_pkg::VSEL_EXT1,
                                    vsel == agr_pkg::VSEL_EXT0};
            INT_VSOURCE_ON <= (vcfg == agr_pkg::VCFG_ALWAYS) ||
                              (vcfg == agr_pkg::VCFG_PDOFF && !POWER_DOWN);
        end
    end

    // A configuration write restarts the start delay
    assign cfg_wr = WR && (ADDR == agr_pkg::OFS_AMP_GAIN || ADDR == agr_pkg::OFS_SAMPLE_RATE
                    || ADDR == agr_pkg::OFS_VSOURCE);

    agr_delay_timer #(
        .CW(13)
    ) u_timer (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .mod_tick(MOD_TICK),
        .start(cfg_wr),
        .code(cfg_wr && ADDR == agr_pkg::OFS_AMP_GAIN ?
              WDATA[agr_pkg::DELAY_LSB +: 3] : gain_r[agr_pkg::DELAY_LSB +: 3]),
        .busy(START_WAIT_BUSY),
        .done(START_READY)
    );
endmodule : agr_config_regs

// File: core/agr_delay_timer.sv
`timescale 1ns/1ps
module agr_delay_timer #(
    parameter int CW = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic mod_tick,
    input wire logic start,
    input wire logic [2:0] code,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt_r;

    function automatic logic [CW-1:0] delay_of(input logic [2:0] c);
        case (c)
            3'h0: delay_of = agr_pkg::DLY_C0;
            3'h1: delay_of = agr_pkg::DLY_C1;
            3'h2: delay_of = agr_pkg::DLY_C2;
            3'h3: delay_of = agr_pkg::DLY_C3;
            3'h4: delay_of = agr_pkg::DLY_C4;
            3'h5: delay_of = agr_pkg::DLY_C5;
            3'h6: delay_of = agr_pkg::DLY_C6;
            default: delay_of = agr_pkg::DLY_C7;
        endcase
    endfunction : delay_of

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                cnt_r <= delay_of(code);
                busy <= 1'b1;
            end else if (busy && mod_tick) begin
                if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule : agr_delay_timer

// File: core/agr_pkg.sv
package agr_pkg;
    // Register offsets
    localparam logic [7:0] OFS_AMP_GAIN = 8'h03;
    localparam logic [7:0] OFS_SAMPLE_RATE = 8'h04;
    localparam logic [7:0] OFS_VSOURCE = 8'h05;
    // Reset values
    localparam logic [7:0] RST_AMP_GAIN = 8'h00;
    localparam logic [7:0] RST_SAMPLE_RATE = 8'h14;
    localparam logic [7:0] RST_VSOURCE = 8'h10;
    // Gain register fields
    localparam int DELAY_LSB = 5;
    localparam int AMP_EN_LSB = 3;
    localparam int GAIN_LSB = 0;
    // Rate register fields
    localparam int CHOP_BIT = 7;
    localparam int CLKSRC_BIT = 6;
    localparam int MODE_BIT = 5;
    localparam int FILTER_BIT = 4;
    localparam int RATE_LSB = 0;
    // Reference register fields
    localparam int MON_LSB = 6;
    localparam int POS_BUF_BIT = 5;
    localparam int NEG_BUF_BIT = 4;
    localparam int VSEL_LSB = 2;
    localparam int VCFG_LSB = 0;
    // Codes
    localparam logic [1:0] AMP_EN_ON = 2'h1;
    localparam logic [1:0] VSEL_EXT0 = 2'h0;
    localparam logic [1:0] VSEL_EXT1 = 2'h1;
    localparam logic [1:0] VSEL_INT = 2'h2;
    localparam logic [1:0] VCFG_PDOFF = 2'h1;
    localparam logic [1:0] VCFG_ALWAYS = 2'h2;
    localparam logic [3:0] RATE_RSVD = 4'hF;
    // Start delay in modulator periods per code 0..7
    localparam logic [12:0] DLY_C0 = 13'h000E;
    localparam logic [12:0] DLY_C1 = 13'h0019;
    localparam logic [12:0] DLY_C2 = 13'h0040;
    localparam logic [12:0] DLY_C3 = 13'h0100;
    localparam logic [12:0] DLY_C4 = 13'h0400;
    localparam logic [12:0] DLY_C5 = 13'h0800;
    localparam logic [12:0] DLY_C6 = 13'h1000;
    localparam logic [12:0] DLY_C7 = 13'h0001;
endpackage : agr_pkg

// File: dv/agr_config_checker.sv
`timescale 1ns/1ps
module agr_config_checker (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Decoded controls
    input wire logic AMP_POWERED,
    input wire logic AMP_BYPASS,
    input wire logic [7:0] AMP_GAIN,
    input wire logic [3:0] OUTPUT_RATE_CODE,
    input wire logic RATE_VALID,
    input wire logic [2:0] VSOURCE_PAIR_ONEHOT,
    input wire logic START_WAIT_BUSY,
    input wire logic START_READY
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_wr(logic [7:0] a);
        CE && WR && ADDR == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        CE && RD && !WR && ADDR == a;
    endsequence
    a_rdata_idle: assert property (CE && !RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    a_write_read: assert property (s_wr(agr_pkg::OFS_AMP_GAIN) ##1
        s_rd(agr_pkg::OFS_AMP_GAIN) |=> RDATA == $past(WDATA, 2))
        else $error("gain register read back differs");
    a_amp_excl: assert property (AMP_POWERED != AMP_BYPASS)
        else $error("amplifier powered and bypassed together");
    a_gain_write: assert property (s_wr(agr_pkg::OFS_AMP_GAIN) |->
        ##2 AMP_GAIN == (8'h01 << ($past(WDATA, 2) & 8'h07)))
        else $error("gain output wrong after write");
    a_rate_write: assert property (s_wr(agr_pkg::OFS_SAMPLE_RATE) |-> ##2
        ({4'h0, OUTPUT_RATE_CODE} == ($past(WDATA, 2) & 8'h0F)
        && RATE_VALID == (($past(WDATA, 2) & 8'h0F) != 8'h0F)))
        else $error("rate code output wrong after write");
    a_src_onehot: assert property ($onehot0(VSOURCE_PAIR_ONEHOT))
        else $error("more than one source selected");
    a_busy_start: assert property (s_wr(agr_pkg::OFS_AMP_GAIN) |=> START_WAIT_BUSY)
        else $error("start wait not begun after write");
    a_ready_pulse: assert property (START_READY |=> !START_READY)
        else $error("start ready longer than one cycle");
    a_ready_idle: assert property ($rose(START_READY) |-> !START_WAIT_BUSY)
        else $error("start ready while still waiting");
endmodule : agr_config_checker

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic REF_CLK = 1'b0, RST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
    logic MOD_TICK = 1'b0, POWER_DOWN = 1'b0, AMP_POWERED, AMP_BYPASS, CHOP_EN, CLK_EXT_SEL;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, AMP_GAIN, m[0:255], a, d;
    logic SINGLE_SHOT, FILTER_LOW_LAT, RATE_VALID, POS_VSOURCE_BUFFER_BYPASS;
    logic NEG_VSOURCE_BUFFER_BYPASS, INT_VSOURCE_ON, START_WAIT_BUSY, START_READY;
    logic [3:0] OUTPUT_RATE_CODE;
    logic [1:0] VSOURCE_MONITOR_CFG;
    logic [2:0] VSOURCE_PAIR_ONEHOT;
    int n_mismatch = 0, n_compared = 0, n, i;
    int dly[8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};
    wire [9:0] amp_o = {AMP_POWERED, AMP_BYPASS, AMP_GAIN};
    wire [8:0] rate_o = {CHOP_EN, CLK_EXT_SEL, SINGLE_SHOT, FILTER_LOW_LAT, OUTPUT_RATE_CODE,
        RATE_VALID};
    wire [7:0] vsrc_o = {VSOURCE_MONITOR_CFG, POS_VSOURCE_BUFFER_BYPASS,
        NEG_VSOURCE_BUFFER_BYPASS, VSOURCE_PAIR_ONEHOT, INT_VSOURCE_ON};
    agr_config_regs i_dut (.*);
    always #12.5 REF_CLK = ~REF_CLK;
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One strobe cycle; the next call or idle lowers it
    task acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge REF_CLK);
        WR <= w;
        RD <= !w;
        ADDR <= ad;
        WDATA <= d;
    endtask : acc
    task idle;
        @(posedge REF_CLK);
        WR <= 1'b0;
        RD <= 1'b0;
    endtask : idle
    task rd(input logic [7:0] ad);
        acc(1'b0, ad, 8'h00);
        idle();
        #1;
        chk("rdata", m[ad], RDATA);
    endtask : rd
    task outs;
        logic [7:0] g, r, v;
        g = m[3];
        r = m[4];
        v = m[5];
        chk("amp", amp_o, {g[4:3] == 2'h1, g[4:3] != 2'h1, 8'h01 << g[2:0]});
        chk("rate", rate_o, {r, r[3:0] != 4'hF});
        chk("vsrc", vsrc_o, {v[7:4], v[3:2] == 2'h3 ? 3'h0 : 3'h1 << v[3:2],
            v[1:0] == 2'h2 || (v[1:0] == 2'h1 && !POWER_DOWN)});
    endtask : outs
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(32'hd241));
        m = '{default: 8'h00};
        m[4] = 8'h14;
        m[5] = 8'h10;
        repeat (5) @(posedge REF_CLK);
        RST <= 1'b0;
        for (i = 1; i < 8; i++) rd(8'(i));
        outs();
        for (i = 0; i < 40; i++) begin
            a = 8'h02 + 8'($urandom % 5);
            d = 8'($urandom);
            acc(1'b1, a, d);
            POWER_DOWN <= 1'($urandom);
            MOD_TICK <= 1'($urandom);
            if (a inside {[8'h03 : 8'h05]}) m[a] = d;
            rd(a);
            outs();
        end
        // Bypass with unity gain as software must program it
        acc(1'b1, 8'h03, 8'h00);
        m[3] = 8'h00;
        rd(8'h03);
        outs();
        @(posedge REF_CLK);
        MOD_TICK <= 1'b1;
        for (i = 0; i < 8; i++) begin
            acc(1'b1, 8'h03, 8'(i << 5));
            m[3] = 8'(i << 5);
            idle();
            n = 0;
            #1;
            while (START_WAIT_BUSY === 1'b1 && n < 5000) begin
                n++;
                @(posedge REF_CLK);
                #1;
            end
            if (n >= 5000) begin
                n_mismatch++;
                final_report();
            end
            chk("delay", 16'(dly[i]), 16'(n));
        end
        @(posedge REF_CLK);
        CE <= 1'b0;
        acc(1'b1, 8'h03, 8'hFF);
        idle();
        CE <= 1'b1;
        rd(8'h03);
        final_report();
    end
endmodule : testbench
bind agr_config_regs agr_config_checker i_chk (.*);
